// file: core/dual_timer_regs.svh
/*
  Register offsets, field positions, reset values and prescaler counts of the
  cascadable dual timer.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

// register offsets, as seen on the plain register port
`define OFS_TIMER_LOW_COUNT 16'h0106
`define OFS_TIMER_HIGH_HOLDING 16'h0108
`define OFS_TIMER_HIGH_COUNT 16'h010a
`define OFS_PERIOD_LOW 16'h010c
`define OFS_PERIOD_HIGH 16'h010e
`define OFS_TIMER_LOW_CONTROL 16'h0110
`define OFS_TIMER_HIGH_CONTROL 16'h0112
`define OFS_INTERRUPT_FLAG_REG0 16'h0084
`define OFS_INTERRUPT_ENABLE_REG0 16'h008c

// control register fields
`define BIT_TIMER_ON 15
`define BIT_STOP_IN_IDLE 13
`define BIT_GATED_ACCUMULATE 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_COMBINE_32BIT 3
`define BIT_CLOCK_SOURCE 1

// implemented bits of each control register
`define MASK_TIMER_LOW_CONTROL 16'ha07a
`define MASK_TIMER_HIGH_CONTROL 16'ha072

// interrupt flag and enable bit positions
`define BIT_LOW_INTERRUPT 6
`define BIT_PAIR_INTERRUPT 7
`define MASK_INTERRUPT_BITS 8'hc0

// reset values
`define RST_COUNT 16'h0000
`define RST_PERIOD 16'hffff
`define RST_CONTROL 16'h0000

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define PS_CNT_W 8
`define PS_LAST_1 8'h00
`define PS_LAST_8 8'h07
`define PS_LAST_64 8'h3f
`define PS_LAST_256 8'hff

`endif

// file: core/dual_timer_pkg.sv
/*
  Types shared by the dual timer and its prescaler.
  Assumes dual_timer_regs.svh is on the include path.
*/
`include "dual_timer_regs.svh"

package dual_timer_pkg;

   typedef enum logic [1:0] {
      PS_DIV_1 = 2'b00,
      PS_DIV_8 = 2'b01,
      PS_DIV_64 = 2'b10,
      PS_DIV_256 = 2'b11
   } prescale_select_t;

   typedef struct packed {
      logic [`PS_CNT_W-1:0] count;
      logic tick;
   } prescale_state_t;

   typedef struct packed {
      logic [15:0] timer_low_count;
      logic [15:0] timer_high_count;
      logic [15:0] timer_high_holding;
      logic [15:0] period_low;
      logic [15:0] period_high;
      logic [15:0] timer_low_control;
      logic [15:0] timer_high_control;
      logic [7:0] interrupt_flag_reg0;
      logic [7:0] interrupt_enable_reg0;
      logic [15:0] rdata;
      logic pin_low_prev;
      logic pin_high_prev;
      logic low_match;
      logic pair_event;
      logic adc_trigger;
   } timer_state_t;

endpackage

// file: core/prescale_if.sv
/*
  Carrier between the timer core and one prescaler.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps

interface prescale_if;
   logic tick_in;
   logic clear;
   logic [1:0] sel;
   logic tick_out;

   modport user (output tick_in, output clear, output sel, input tick_out);
   modport core (input tick_in, input clear, input sel, output tick_out);
endinterface

// file: core/timer_prescaler.sv
/*
  One 1:1/8/64/256 prescaler. SYNC_OUT registers the output tick, which the
  low-half timer uses to resynchronise its clock to the internal clock.
  Assumes tick_in is a one-cycle enable in the clk_sys domain.
*/
`timescale 1ns/1ps

module timer_prescaler import dual_timer_pkg::*; #(
   parameter bit SYNC_OUT = 1'b0,
   parameter int CNT_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   prescale_if.core ps
);

   prescale_state_t s_q;
   prescale_state_t s_d;
   logic [`PS_CNT_W-1:0] last;
   logic hit;

   initial begin
      if (CNT_W != `PS_CNT_W) begin
         $error("prescaler width must match the 1:256 ratio");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // terminal count per ratio, then count or clear
   always_comb begin
      case (prescale_select_t'(ps.sel))
         PS_DIV_1: last = `PS_LAST_1;
         PS_DIV_8: last = `PS_LAST_8;
         PS_DIV_64: last = `PS_LAST_64;
         PS_DIV_256: last = `PS_LAST_256;
         default: last = `PS_LAST_1;
      endcase
      hit = ps.tick_in && (s_q.count == last);
      s_d = s_q;
      if (ps.clear) begin
         s_d.count = '0;
      end else if (ps.tick_in) begin
         s_d.count = hit ? '0 : s_q.count + 1'b1;
      end
      s_d.tick = hit && !ps.clear;
   end

   // synchronised output costs one cycle of latency on the low half only
   assign ps.tick_out = SYNC_OUT ? s_q.tick : (hit && !ps.clear);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

endmodule

// file: core/cascadable_dual_timer_32bit.sv
/*
  Pair of 16-bit timers, usable as two independent timers or as one 32-bit
  timer / synchronous counter, with period match, prescaler, gated
  accumulation, ADC trigger and interrupt flag/enable bits.
  Assumes a register master on a plain port with single-cycle strobes and
  read data one cycle later; all pins synchronous to clk_sys.
*/
`timescale 1ns/1ps

module cascadable_dual_timer_32bit import dual_timer_pkg::*; #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic external_clock_gate_pin,
   input wire logic external_clock_high_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic low_match_event,
   output logic pair_event,
   output logic adc_trigger,
   output logic irq
);

   timer_state_t s_q;
   timer_state_t s_d;

   prescale_if ps_low ();
   prescale_if ps_high ();

   initial begin
      if (ADDR_W != 16 || DATA_W != 16) begin
         $error("dual timer needs 16-bit address and data");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register decode

   logic wr_low_count;
   logic wr_high_count;
   logic wr_holding;
   logic wr_period_low;
   logic wr_period_high;
   logic wr_ctl_low;
   logic wr_ctl_high;
   logic wr_flag;
   logic wr_enable;
   logic rd_low_count;

   // one-hot write strokes per register
   assign wr_low_count = reg_wr && (reg_addr == `OFS_TIMER_LOW_COUNT);
   assign wr_high_count = reg_wr && (reg_addr == `OFS_TIMER_HIGH_COUNT);
   assign wr_holding = reg_wr && (reg_addr == `OFS_TIMER_HIGH_HOLDING);
   assign wr_period_low = reg_wr && (reg_addr == `OFS_PERIOD_LOW);
   assign wr_period_high = reg_wr && (reg_addr == `OFS_PERIOD_HIGH);
   assign wr_ctl_low = reg_wr && (reg_addr == `OFS_TIMER_LOW_CONTROL);
   assign wr_ctl_high = reg_wr && (reg_addr == `OFS_TIMER_HIGH_CONTROL);
   assign wr_flag = reg_wr && (reg_addr == `OFS_INTERRUPT_FLAG_REG0);
   assign wr_enable = reg_wr && (reg_addr == `OFS_INTERRUPT_ENABLE_REG0);
   assign rd_low_count = reg_rd && (reg_addr == `OFS_TIMER_LOW_COUNT);

   ////////////////////////////////////////////////////////////////////////////
   // control fields

   logic combine_32bit_select;
   logic low_timer_on;
   logic high_timer_on;
   logic low_stop_in_idle;
   logic high_stop_in_idle;
   logic low_gated;
   logic high_gated;
   logic low_clock_source_select;
   logic high_clock_source_select;

   // in 32-bit mode the high control register acts only through its enable being cleared, which clears the high prescaler and, while the low timer is on, the low one
   assign combine_32bit_select = s_q.timer_low_control[`BIT_COMBINE_32BIT];
   assign low_timer_on = s_q.timer_low_control[`BIT_TIMER_ON];
   assign high_timer_on = s_q.timer_high_control[`BIT_TIMER_ON];
   assign low_stop_in_idle = s_q.timer_low_control[`BIT_STOP_IN_IDLE];
   assign high_stop_in_idle = s_q.timer_high_control[`BIT_STOP_IN_IDLE];
   assign low_clock_source_select = s_q.timer_low_control[`BIT_CLOCK_SOURCE];
   assign high_clock_source_select = s_q.timer_high_control[`BIT_CLOCK_SOURCE];
   // gating needs the internal clock selected
   assign low_gated = s_q.timer_low_control[`BIT_GATED_ACCUMULATE] && !low_clock_source_select;
   assign high_gated = s_q.timer_high_control[`BIT_GATED_ACCUMULATE] && !high_clock_source_select;

   ////////////////////////////////////////////////////////////////////////////
   // run conditions and prescaler inputs

   logic low_run;
   logic high_run;
   logic low_pin_rise;
   logic high_pin_rise;
   logic low_gate_fall;
   logic high_gate_fall;
   logic low_ton_clear;
   logic high_ton_clear;
   logic any_count_write;

   // sleep stops the internal clocks; idle stops only when asked to
   assign low_run = low_timer_on && !cpu_sleep && !(cpu_idle && low_stop_in_idle);
   assign high_run = high_timer_on && !cpu_sleep && !(cpu_idle && high_stop_in_idle) && !combine_32bit_select;

   // edges seen against last cycle's pin level
   assign low_pin_rise = external_clock_gate_pin && !s_q.pin_low_prev;
   assign high_pin_rise = external_clock_high_pin && !s_q.pin_high_prev;
   assign low_gate_fall = low_timer_on && low_gated && !external_clock_gate_pin && s_q.pin_low_prev;
   assign high_gate_fall = high_run && high_gated && !external_clock_high_pin && s_q.pin_high_prev;

   // enable bit written from one to zero
   assign low_ton_clear = wr_ctl_low && low_timer_on && !reg_wdata[`BIT_TIMER_ON];
   assign high_ton_clear = wr_ctl_high && high_timer_on && !reg_wdata[`BIT_TIMER_ON];
   assign any_count_write = wr_low_count || wr_high_count;

   // external source counts rising edges; internal counts every cycle or while gate high
   always_comb begin
      if (!low_run) begin
         ps_low.tick_in = 1'b0;
      end else if (low_clock_source_select) begin
         ps_low.tick_in = low_pin_rise;
      end else if (low_gated) begin
         ps_low.tick_in = external_clock_gate_pin;
      end else begin
         ps_low.tick_in = 1'b1;
      end
   end

   always_comb begin
      if (!high_run) begin
         ps_high.tick_in = 1'b0;
      end else if (high_clock_source_select) begin
         ps_high.tick_in = high_pin_rise;
      end else if (high_gated) begin
         ps_high.tick_in = external_clock_high_pin;
      end else begin
         ps_high.tick_in = 1'b1;
      end
   end

   // the low prescaler is cleared only while the low timer is on; while off it keeps its count
   assign ps_low.clear = low_timer_on && (any_count_write || low_ton_clear || high_ton_clear);
   assign ps_high.clear = any_count_write || low_ton_clear || high_ton_clear;
   assign ps_low.sel = s_q.timer_low_control[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];
   assign ps_high.sel = s_q.timer_high_control[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];

   timer_prescaler #(
      .SYNC_OUT(1'b1),
      .CNT_W(`PS_CNT_W)
   ) u_prescale_low (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .ps(ps_low)
   );

   timer_prescaler #(
      .SYNC_OUT(1'b0),
      .CNT_W(`PS_CNT_W)
   ) u_prescale_high (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .ps(ps_high)
   );

   ////////////////////////////////////////////////////////////////////////////
   // counting and match detection

   logic [31:0] pair_count;
   logic [31:0] pair_period;
   logic [31:0] pair_next;
   logic pair_match;
   logic low_match;
   logic high_match;

   assign pair_count = {s_q.timer_high_count, s_q.timer_low_count};
   assign pair_period = {s_q.period_high, s_q.period_low};
   assign pair_next = pair_count + 32'h0000_0001;
   // the 32-bit clock comes from the low prescaler alone
   assign pair_match = combine_32bit_select && ps_low.tick_out && (pair_count == pair_period);
   assign low_match = !combine_32bit_select && ps_low.tick_out && (s_q.timer_low_count == s_q.period_low);
   assign high_match = !combine_32bit_select && ps_high.tick_out && (s_q.timer_high_count == s_q.period_high);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      s_d.pin_low_prev = external_clock_gate_pin;
      s_d.pin_high_prev = external_clock_high_pin;
      s_d.low_match = 1'b0;
      s_d.pair_event = 1'b0;
      s_d.adc_trigger = 1'b0;

      // counter advance; the gate falling edge simply stops ticks
      if (combine_32bit_select) begin
         if (ps_low.tick_out) begin
            if (pair_match) begin
               s_d.timer_low_count = `RST_COUNT;
               s_d.timer_high_count = `RST_COUNT;
            end else begin
               s_d.timer_low_count = pair_next[15:0];
               s_d.timer_high_count = pair_next[31:16];
            end
         end
      end else begin
         if (ps_low.tick_out) begin
            s_d.timer_low_count = low_match ? `RST_COUNT : s_q.timer_low_count + 16'h0001;
         end
         if (ps_high.tick_out) begin
            s_d.timer_high_count = high_match ? `RST_COUNT : s_q.timer_high_count + 16'h0001;
         end
      end

      // software writes override a tick in the same cycle
      if (wr_low_count) begin
         s_d.timer_low_count = reg_wdata;
         if (combine_32bit_select) begin
            s_d.timer_high_count = s_q.timer_high_holding;
         end
      end
      if (wr_high_count) begin
         s_d.timer_high_count = reg_wdata;
      end
      if (wr_holding) begin
         s_d.timer_high_holding = reg_wdata;
      end
      if (rd_low_count) begin
         s_d.timer_high_holding = s_q.timer_high_count;
      end
      if (wr_period_low) begin
         s_d.period_low = reg_wdata;
      end
      if (wr_period_high) begin
         s_d.period_high = reg_wdata;
      end
      // control writes touch control bits only
      if (wr_ctl_low) begin
         s_d.timer_low_control = reg_wdata & `MASK_TIMER_LOW_CONTROL;
      end
      if (wr_ctl_high) begin
         s_d.timer_high_control = reg_wdata & `MASK_TIMER_HIGH_CONTROL;
      end
      if (wr_enable) begin
         s_d.interrupt_enable_reg0 = reg_wdata[7:0] & `MASK_INTERRUPT_BITS;
      end

      // events; a set in the same cycle as a software clear wins
      if (wr_flag) begin
         s_d.interrupt_flag_reg0 = reg_wdata[7:0] & `MASK_INTERRUPT_BITS;
      end
      if (pair_match || (combine_32bit_select && low_gate_fall) || high_match ||
          (!combine_32bit_select && high_gate_fall)) begin
         s_d.interrupt_flag_reg0[`BIT_PAIR_INTERRUPT] = 1'b1;
         s_d.pair_event = 1'b1;
      end
      if (low_match || (!combine_32bit_select && low_gate_fall)) begin
         s_d.interrupt_flag_reg0[`BIT_LOW_INTERRUPT] = 1'b1;
         s_d.low_match = 1'b1;
      end
      if (pair_match) begin
         s_d.adc_trigger = 1'b1;
      end

      // read data stand in the cycle after the strobe only
      s_d.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `OFS_TIMER_LOW_COUNT: s_d.rdata = s_q.timer_low_count;
            `OFS_TIMER_HIGH_HOLDING: s_d.rdata = s_q.timer_high_holding;
            `OFS_TIMER_HIGH_COUNT: s_d.rdata = s_q.timer_high_count;
            `OFS_PERIOD_LOW: s_d.rdata = s_q.period_low;
            `OFS_PERIOD_HIGH: s_d.rdata = s_q.period_high;
            `OFS_TIMER_LOW_CONTROL: s_d.rdata = s_q.timer_low_control;
            `OFS_TIMER_HIGH_CONTROL: s_d.rdata = s_q.timer_high_control;
            `OFS_INTERRUPT_FLAG_REG0: s_d.rdata = {8'h00, s_q.interrupt_flag_reg0};
            `OFS_INTERRUPT_ENABLE_REG0: s_d.rdata = {8'h00, s_q.interrupt_enable_reg0};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; clock enable low freezes everything

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.period_low <= `RST_PERIOD;
         s_q.period_high <= `RST_PERIOD;
         s_q.timer_low_control <= `RST_CONTROL;
         s_q.timer_high_control <= `RST_CONTROL;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // the enable gates the flag onto the one interrupt line
   assign irq = |(s_q.interrupt_flag_reg0 & s_q.interrupt_enable_reg0);
   assign reg_rdata = s_q.rdata;
   assign low_match_event = s_q.low_match;
   assign pair_event = s_q.pair_event;
   assign adc_trigger = s_q.adc_trigger;

endmodule

// file: bench/pin_source.sv
/*
  Model of the outside world on the clock/gate pin: a level pulse for gating
  or a train of rising edges for the counter.
  Assumes start is a one-cycle request on clk_sys.
*/
`timescale 1ns/1ps

module pin_source (
   input wire logic clk_sys,
   input wire logic start,
   input wire logic edges,
   input wire logic [7:0] len,
   output logic pin,
   output logic busy
);
   // pin idles low, the level a gate sees as closed; one process owns pin and busy
   // edges: len pulses of 2 high, 2 low; else one high level of len cycles
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (start === 1'b1) begin
            busy <= 1'b1;
            if (edges) begin
               repeat (len) begin
                  pin <= 1'b1;
                  repeat (2) @(posedge clk_sys);
                  pin <= 1'b0;
                  repeat (2) @(posedge clk_sys);
               end
            end else begin
               pin <= 1'b1;
               repeat (len) @(posedge clk_sys);
               pin <= 1'b0;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// file: bench/cascadable_dual_timer_32bit_asserts.sv
/*
  Port checker for the dual timer, bound into the top module.
  Assumes dual_timer_regs.svh on the include path.
*/
`timescale 1ns/1ps
`include "dual_timer_regs.svh"

module cascadable_dual_timer_32bit_asserts import dual_timer_pkg::*; #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic cpu_sleep,
   input wire logic low_match_event,
   input wire logic pair_event,
   input wire logic adc_trigger,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////
   sequence s_rd_low_ctrl;
      reg_rd && reg_addr == `OFS_TIMER_LOW_CONTROL;
   endsequence
   sequence s_rd_high_ctrl;
      reg_rd && reg_addr == `OFS_TIMER_HIGH_CONTROL;
   endsequence
   // four cycles lets any tick already in flight drain out
   sequence s_long_sleep;
      cpu_sleep [*4];
   endsequence

   a_low_ctrl_mask: assert property (s_rd_low_ctrl |=> (reg_rdata & ~`MASK_TIMER_LOW_CONTROL) == '0)
      else $error("low control shows unimplemented bits");
   a_high_ctrl_mask: assert property (s_rd_high_ctrl |=> (reg_rdata & ~`MASK_TIMER_HIGH_CONTROL) == '0)
      else $error("high control shows unimplemented bits");
   a_adc_single: assert property (adc_trigger |=> !adc_trigger)
      else $error("adc trigger longer than one cycle");
   a_adc_sets_flag: assert property (adc_trigger |-> pair_event)
      else $error("32-bit match without pair flag event");
   a_adc_not_16: assert property (low_match_event |-> !adc_trigger)
      else $error("adc trigger on a 16-bit match");
   a_irq_rise_cause: assert property ($rose(irq) |-> pair_event || low_match_event || $past(reg_wr))
      else $error("irq rose without an event or write");
   a_irq_fall_sw: assert property ($fell(irq) |-> $past(reg_wr))
      else $error("irq fell without a software write");
   a_sleep_quiet: assert property (s_long_sleep |-> !pair_event && !low_match_event)
      else $error("timer event during sleep");
endmodule

bind cascadable_dual_timer_32bit cascadable_dual_timer_32bit_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep), .low_match_event(low_match_event),
   .pair_event(pair_event), .adc_trigger(adc_trigger), .irq(irq));

// file: bench/cascadable_dual_timer_32bit_tb.sv
/*
  Self-checking bench for the dual timer: register tasks and scenarios.
  Assumes the checker is bound in and pin_source drives the clock/gate pin.
*/
`timescale 1ns/1ps
`include "dual_timer_regs.svh"

module cascadable_dual_timer_32bit_tb import dual_timer_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cpu_idle = 1'b0;
   logic cpu_sleep = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata, a, b;
   logic low_ev, pair_ev, adc, irq, pin, pbusy;
   logic pstart = 1'b0;
   logic pedges = 1'b0;
   logic [7:0] plen = 8'h00;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   int div [4] = '{1, 8, 64, 256};

   always #20 clk_sys = ~clk_sys;

   cascadable_dual_timer_32bit dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_clock_gate_pin(pin),
      .external_clock_high_pin(pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
      .low_match_event(low_ev), .pair_event(pair_ev), .adc_trigger(adc), .irq(irq));

   pin_source pin_u (.clk_sys(clk_sys), .start(pstart), .edges(pedges), .len(plen), .pin(pin), .busy(pbusy));

   ////////////////////////////////////////
   task automatic results;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // strobes start one edge after the call, so back-to-back calls never clash
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [15:0] ad, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      // data stand only in this cycle; take them once settled
      #1;
      d = reg_rdata;
      @(posedge clk_sys);
   endtask

   task automatic chk(input logic [15:0] ad, input logic [15:0] exp);
      logic [15:0] d;
      rd(ad, d);
      cmp(d, exp);
   endtask

   // cycles until pair (0), adc (1) or low (2) event, bounded
   task automatic wait_ev(input int sel, output int k);
      logic hit;
      k = 0;
      hit = 1'b0;
      while (!hit && k < 2000) begin
         @(posedge clk_sys);
         #1;
         k++;
         hit = sel == 0 ? pair_ev === 1'b1 : sel == 1 ? adc === 1'b1 : low_ev === 1'b1;
      end
      if (!hit) begin
         miscompares++;
         $display("Error at %0t: event wait ran out, got %h expected %h", $time, hit, 1'b1);
      end
   endtask

   // pair events in cycles 5..20 of an idle or sleep spell
   task automatic quiet(input logic idl, input logic slp, output int k);
      @(posedge clk_sys);
      cpu_idle <= idl;
      cpu_sleep <= slp;
      k = 0;
      for (int i = 1; i <= 20; i++) begin
         @(posedge clk_sys);
         #1;
         if (i > 4 && pair_ev === 1'b1)
            k++;
      end
      @(posedge clk_sys);
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b0;
   endtask

   task automatic pins(input logic e, input logic [7:0] l);
      @(posedge clk_sys);
      pedges <= e;
      plen <= l;
      pstart <= 1'b1;
      @(posedge clk_sys);
      pstart <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 2000 && pbusy === 1'b1; i++)
         @(posedge clk_sys);
      if (pbusy === 1'b1) begin
         miscompares++;
         $display("Error at %0t: pin model still busy, got %h expected %h", $time, pbusy, 1'b0);
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // a hang counts as a mismatch
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         results();
      end
   end

   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk(`OFS_PERIOD_LOW, 16'hffff);
      chk(`OFS_PERIOD_HIGH, 16'hffff);
      chk(`OFS_TIMER_LOW_COUNT, 16'h0000);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h5f85);
      wr(`OFS_TIMER_HIGH_CONTROL, 16'h5f85);
      chk(`OFS_TIMER_LOW_CONTROL, 16'h0000);
      chk(`OFS_TIMER_HIGH_CONTROL, 16'h0000);
      wr(16'h0200, 16'hbeef);
      chk(16'h0200, 16'h0000);
      wr(`OFS_TIMER_LOW_COUNT, 16'h1234);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h0038);
      chk(`OFS_TIMER_LOW_COUNT, 16'h1234);
      wr(`OFS_TIMER_HIGH_HOLDING, 16'habcd);
      wr(`OFS_TIMER_LOW_COUNT, 16'h5678);
      chk(`OFS_TIMER_HIGH_COUNT, 16'habcd);
      wr(`OFS_TIMER_HIGH_HOLDING, 16'h0000);
      chk(`OFS_TIMER_LOW_COUNT, 16'h5678);
      chk(`OFS_TIMER_HIGH_HOLDING, 16'habcd);
      // 32-bit run across the half carry
      wr(`OFS_PERIOD_LOW, 16'h0002);
      wr(`OFS_PERIOD_HIGH, 16'h0001);
      wr(`OFS_TIMER_HIGH_HOLDING, 16'h0000);
      wr(`OFS_TIMER_LOW_COUNT, 16'hfffe);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h8008);
      wait_ev(1, n);
      cmp(16'(n), 16'h0006);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h0008);
      chk(`OFS_INTERRUPT_FLAG_REG0, 16'h0080);
      cmp({15'h0000, irq}, 16'h0000);
      wr(`OFS_INTERRUPT_ENABLE_REG0, 16'h0080);
      cmp({15'h0000, irq}, 16'h0001);
      wr(`OFS_INTERRUPT_FLAG_REG0, 16'h0000);
      cmp({15'h0000, irq}, 16'h0000);
      // ratio sweep; high control is set to mislead and must be ignored
      wr(`OFS_PERIOD_LOW, 16'h0001);
      wr(`OFS_PERIOD_HIGH, 16'h0000);
      wr(`OFS_TIMER_HIGH_CONTROL, 16'h8030);
      for (int r = 0; r < 4; r++) begin
         wr(`OFS_TIMER_LOW_COUNT, 16'h0000);
         wr(`OFS_TIMER_LOW_CONTROL, 16'h8008 | 16'(r << 4));
         wait_ev(0, n);
         wait_ev(0, n);
         cmp(16'(n), 16'(2 * div[r]));
         wr(`OFS_TIMER_LOW_CONTROL, 16'h0008);
      end
      // idle and sleep
      wr(`OFS_TIMER_LOW_CONTROL, 16'ha008);
      quiet(1'b1, 1'b0, n);
      cmp(16'(n), 16'h0000);
      wait_ev(0, n);
      cmp(16'(n <= 6), 16'h0001);
      quiet(1'b0, 1'b1, n);
      cmp(16'(n), 16'h0000);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h8008);
      quiet(1'b1, 1'b0, n);
      cmp(16'(n), 16'h0008);
      // gated accumulation over a 40-cycle gate
      wr(`OFS_TIMER_LOW_CONTROL, 16'h0008);
      wr(`OFS_PERIOD_LOW, 16'hffff);
      wr(`OFS_TIMER_LOW_COUNT, 16'h0000);
      wr(`OFS_INTERRUPT_FLAG_REG0, 16'h0000);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h8048);
      chk(`OFS_TIMER_LOW_COUNT, 16'h0000);
      pins(1'b0, 8'h28);
      rd(`OFS_TIMER_LOW_COUNT, a);
      rd(`OFS_TIMER_LOW_COUNT, b);
      cmp(b, a);
      cmp(16'(a >= 16'h0024 && a <= 16'h0029), 16'h0001);
      chk(`OFS_INTERRUPT_FLAG_REG0, 16'h0080);
      // synchronous counter on five pin edges
      wr(`OFS_TIMER_LOW_CONTROL, 16'h000a);
      wr(`OFS_TIMER_LOW_COUNT, 16'h0000);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h800a);
      pins(1'b1, 8'h05);
      chk(`OFS_TIMER_LOW_COUNT, 16'h0005);
      // two independent 16-bit timers
      wr(`OFS_TIMER_LOW_CONTROL, 16'h0000);
      wr(`OFS_TIMER_HIGH_COUNT, 16'h0000);
      wr(`OFS_TIMER_LOW_COUNT, 16'h0000);
      wr(`OFS_PERIOD_HIGH, 16'h0002);
      wr(`OFS_PERIOD_LOW, 16'h0003);
      wr(`OFS_TIMER_HIGH_CONTROL, 16'h8000);
      wr(`OFS_TIMER_LOW_CONTROL, 16'h8000);
      wait_ev(0, n);
      wait_ev(0, n);
      cmp(16'(n), 16'h0003);
      wait_ev(2, n);
      wait_ev(2, n);
      cmp(16'(n), 16'h0004);
      // high timer as a synchronous counter on its own pin, period 2
      wr(`OFS_TIMER_HIGH_CONTROL, 16'h0002);
      wr(`OFS_TIMER_HIGH_COUNT, 16'h0000);
      wr(`OFS_TIMER_HIGH_CONTROL, 16'h8002);
      pins(1'b1, 8'h05);
      chk(`OFS_TIMER_HIGH_COUNT, 16'h0002);
      results();
   end
endmodule
